// *** hw/t8pwm_pkg.sv ***
// Constants, field layouts and types shared by the 8-bit timer waveform block.
package t8pwm_pkg;

  // Register addresses in the I/O data space.
  localparam logic [7:0] T8PWM_ADDR_CTRL_A = 8'h44;
  localparam logic [7:0] T8PWM_ADDR_CTRL_B = 8'h45;
  localparam logic [7:0] T8PWM_ADDR_COUNT = 8'h46;
  localparam logic [7:0] T8PWM_ADDR_CMP_A = 8'h47;
  localparam logic [7:0] T8PWM_ADDR_FLAGS = 8'h35;

  // Values after reset and counter end points.
  localparam logic [7:0] T8PWM_RST_BYTE = 8'h00;
  localparam logic [7:0] T8PWM_BOTTOM = 8'h00;
  localparam logic [7:0] T8PWM_MAX = 8'hFF;
  localparam logic [7:0] T8PWM_ONE = 8'h01;

  // Waveform mode selector codes, high bit first.
  localparam logic [2:0] T8PWM_WGM_NORMAL = 3'h0;
  localparam logic [2:0] T8PWM_WGM_PC_FIXED = 3'h1;
  localparam logic [2:0] T8PWM_WGM_CTC = 3'h2;
  localparam logic [2:0] T8PWM_WGM_FAST_FIXED = 3'h3;
  localparam logic [2:0] T8PWM_WGM_PC_CMP = 3'h5;
  localparam logic [2:0] T8PWM_WGM_FAST_CMP = 3'h7;

  // Channel output mode codes.
  localparam logic [1:0] T8PWM_COM_OFF = 2'h0;
  localparam logic [1:0] T8PWM_COM_TOGGLE = 2'h1;
  localparam logic [1:0] T8PWM_COM_CLEAR = 2'h2;
  localparam logic [1:0] T8PWM_COM_SET = 2'h3;

  // Bit positions in control register B and the flag register.
  localparam int T8PWM_CTRLB_FORCE_A = 7;
  localparam int T8PWM_CTRLB_WGM_HIGH = 3;
  localparam int T8PWM_FLAG_OVF = 0;
  localparam int T8PWM_FLAG_CMPA = 1;

  // Tick source selections and prescaler masks.
  localparam logic [2:0] T8PWM_CS_STOP = 3'h0;
  localparam logic [2:0] T8PWM_CS_DIV1 = 3'h1;
  localparam logic [2:0] T8PWM_CS_DIV8 = 3'h2;
  localparam logic [2:0] T8PWM_CS_DIV64 = 3'h3;
  localparam logic [2:0] T8PWM_CS_DIV256 = 3'h4;
  localparam logic [2:0] T8PWM_CS_DIV1024 = 3'h5;
  localparam logic [9:0] T8PWM_MASK_DIV8 = 10'h007;
  localparam logic [9:0] T8PWM_MASK_DIV64 = 10'h03F;
  localparam logic [9:0] T8PWM_MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] T8PWM_MASK_DIV1024 = 10'h3FF;
  localparam logic [9:0] T8PWM_PRESC_RST = 10'h000;

  // Layout of control register A.
  typedef struct packed {
    logic [1:0] chan_a_out_mode;
    logic [1:0] chan_b_out_mode;
    logic [1:0] rsvd;
    logic [1:0] wave_mode_sel;
  } t8pwm_ctrl_a_t;

  // One access on the I/O register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } t8pwm_io_req_t;

  // Counting direction; one bit, so trivially Gray.
  typedef enum logic [0:0] {
    T8PWM_UP = 1'b0,
    T8PWM_DOWN = 1'b1
  } t8pwm_dir_t;

endpackage

// *** hw/t8pwm_presc.sv ***
// Prescaler that turns the I/O clock into the timer tick enable.
`timescale 1ns/1ps
module t8pwm_presc (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_tick_source_sel,
  output logic o_tick
);
  import t8pwm_pkg::*;

  logic [9:0] presc_ff; // Free running divider count.
  logic [9:0] nxt_presc;
  logic tick_ff; // Registered tick enable.
  logic nxt_tick;

  // Selects which divider phase produces a tick; stop gives none at all.
  always_comb begin
    nxt_presc = presc_ff + 10'h001;
    case (i_tick_source_sel)
      T8PWM_CS_DIV1: nxt_tick = 1'b1;
      T8PWM_CS_DIV8: nxt_tick = (presc_ff & T8PWM_MASK_DIV8) == T8PWM_MASK_DIV8;
      T8PWM_CS_DIV64: nxt_tick = (presc_ff & T8PWM_MASK_DIV64) == T8PWM_MASK_DIV64;
      T8PWM_CS_DIV256: nxt_tick = (presc_ff & T8PWM_MASK_DIV256) == T8PWM_MASK_DIV256;
      T8PWM_CS_DIV1024: nxt_tick = (presc_ff & T8PWM_MASK_DIV1024) == T8PWM_MASK_DIV1024;
      default: nxt_tick = 1'b0; // Stop and external sources give no tick.
    endcase
  end

  // Registers the divider and the tick; the tick is a clock enable, not a clock.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      presc_ff <= T8PWM_PRESC_RST;
      tick_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;
endmodule // t8pwm_presc

// *** hw/t8pwm_core.sv ***
// Timer counter with phase-correct, fast and non-PWM waveform output for channel A.
// Notes on behaviour
// - Modes 0x1 and 0x5 select phase-correct PWM.
// - Count up to TOP, then down.
// - TOP is 0xFF or compare A value.
// - Counter holds TOP for one tick.
// - Overflow flag set at every BOTTOM.
// - Non-inverted: clear on up, set down.
// - Inverted: set on up, clear down.
// - In the PWM modes, 01 toggles only when high bit set.
// - Nonzero output mode overrides port pin, but 01 only if non-PWM or high bit set.
// - Compare BOTTOM low, MAX high, non-inverted.
// - Leaving MAX forces up result at BOTTOM.
// - Missed up match still takes its transition.
// - Non-PWM: 01 toggle, 10 clear, 11 set.
// - Fast PWM: match action, opposite at BOTTOM.
// - Fast PWM compare at TOP ignores match.
// - Phase-correct compare at TOP acts at TOP.
// - Single clock; tick is clock enable.
// - Fixed TOP period is 510 ticks.
// - Control A layout, all bits reset zero.
// - High mode bit sits in control B.
// - Tick select zero stops the counter.
`timescale 1ns/1ps
module t8pwm_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire t8pwm_pkg::t8pwm_io_req_t i_io_req,
  input wire logic i_port_data_a,
  input wire logic i_port_dir_a,
  output logic [7:0] o_io_rdata,
  output logic o_wave_out_a,
  output logic o_pin_a_out,
  output logic o_pin_a_oe_n,
  output logic o_overflow_flag,
  output logic o_compare_a_flag
);
  import t8pwm_pkg::*;

  t8pwm_ctrl_a_t ctrl_a_ff; // Control register A.
  t8pwm_ctrl_a_t nxt_ctrl_a;
  logic [7:0] ctrl_b_ff; // Control register B; force strobe is never stored.
  logic [7:0] nxt_ctrl_b;
  logic [7:0] count_ff; // Counter value.
  logic [7:0] nxt_count;
  logic [7:0] cmp_buf_ff; // Compare value as written by software.
  logic [7:0] nxt_cmp_buf;
  logic [7:0] cmp_act_ff; // Compare value the logic is using.
  logic [7:0] nxt_cmp_act;
  t8pwm_dir_t dir_ff; // Counting direction.
  t8pwm_dir_t nxt_dir;
  logic [1:0] flags_ff; // Overflow and compare A flags.
  logic [1:0] nxt_flags;
  logic wave_ff; // Waveform value of channel A.
  logic nxt_wave;
  logic leave_max_ff; // Compare value just left MAX.
  logic nxt_leave_max;
  logic up_hit_ff; // An up-counting match was seen on this slope.
  logic nxt_up_hit;
  logic pin_out_ff; // Level driven to the pin.
  logic nxt_pin_out;
  logic pin_oe_n_ff; // Pin driver enable, low while driving.
  logic nxt_pin_oe_n;
  logic [7:0] rdata_ff; // Read data, one cycle after the read.
  logic [7:0] nxt_rdata;

  logic tick; // Timer tick from the prescaler.
  logic [2:0] wgm; // Full waveform mode selector.
  logic [1:0] com; // Channel A output mode.
  logic is_pc; // Phase-correct PWM selected.
  logic is_fast; // Fast PWM selected.
  logic is_nonpwm; // Normal, CTC or an unused mode code selected.
  logic [7:0] top; // Current TOP value.
  logic at_top; // Counter sits at TOP.
  logic match; // Compare match on this tick.
  logic up_res; // Output level an up-counting match gives.
  logic down_res; // Output level a down-counting match gives.
  logic [1:0] flag_set; // Hardware flag events this cycle.
  logic [1:0] flag_clr; // Software clears this cycle.
  logic force_a; // Forced compare strobe.
  logic wave_conn; // Waveform owns the pin in the current mode.

  // The tick only enables the counter; everything runs on i_clk.
  t8pwm_presc u_presc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick_source_sel(ctrl_b_ff[2:0]),
    .o_tick(tick)
  );

  // Decodes mode, TOP and the match levels from the registers.
  always_comb begin
    wgm = {ctrl_b_ff[T8PWM_CTRLB_WGM_HIGH], ctrl_a_ff.wave_mode_sel};
    com = ctrl_a_ff.chan_a_out_mode;
    is_pc = (wgm == T8PWM_WGM_PC_FIXED) || (wgm == T8PWM_WGM_PC_CMP);
    is_fast = (wgm == T8PWM_WGM_FAST_FIXED) || (wgm == T8PWM_WGM_FAST_CMP);
    is_nonpwm = !is_pc && !is_fast;
    // Mode 0x5, 0x7 and CTC take TOP from compare A; the others use MAX.
    if ((wgm == T8PWM_WGM_PC_CMP) || (wgm == T8PWM_WGM_FAST_CMP) || (wgm == T8PWM_WGM_CTC)) begin
      top = cmp_act_ff;
    end else begin
      top = T8PWM_MAX;
    end
    at_top = count_ff == top;
    match = tick && (count_ff == cmp_act_ff);
    up_res = com[0];
    down_res = ~com[0];
    // Code 01 drives the pin only in non-PWM modes or with the high mode bit set.
    wave_conn = com[1] || ((com == T8PWM_COM_TOGGLE) && (is_nonpwm || wgm[2]));
  end

  // Computes every next value: counter, buffers, waveform, flags, pin and bus.
  always_comb begin
    nxt_ctrl_a = ctrl_a_ff;
    nxt_ctrl_b = ctrl_b_ff;
    nxt_count = count_ff;
    nxt_cmp_buf = cmp_buf_ff;
    nxt_cmp_act = cmp_act_ff;
    nxt_dir = dir_ff;
    nxt_wave = wave_ff;
    nxt_leave_max = leave_max_ff;
    nxt_up_hit = up_hit_ff;
    nxt_rdata = rdata_ff;
    flag_set = 2'h0;
    flag_clr = 2'h0;
    force_a = i_io_req.wr && (i_io_req.addr == T8PWM_ADDR_CTRL_B)
              && i_io_req.wdata[T8PWM_CTRLB_FORCE_A] && is_nonpwm;
    // Counter sequence; nothing moves without a tick.
    if (tick && is_pc) begin
      if (dir_ff == T8PWM_UP) begin
        if (count_ff >= top) begin
          // TOP was held for this one tick; turn round now.
          nxt_dir = T8PWM_DOWN;
          nxt_count = (top == T8PWM_BOTTOM) ? T8PWM_BOTTOM : count_ff - T8PWM_ONE;
        end else begin
          nxt_count = count_ff + T8PWM_ONE;
        end
      end else begin
        if (count_ff == T8PWM_BOTTOM) begin
          // BOTTOM is held one tick too, so a MAX TOP gives 510 ticks.
          nxt_dir = T8PWM_UP;
          nxt_count = (top == T8PWM_BOTTOM) ? T8PWM_BOTTOM : T8PWM_ONE;
          flag_set[T8PWM_FLAG_OVF] = 1'b1;
        end else begin
          nxt_count = count_ff - T8PWM_ONE;
        end
      end
    end else if (tick) begin
      // Single-slope modes count up only.
      nxt_dir = T8PWM_UP;
      if ((is_fast || (wgm == T8PWM_WGM_CTC)) && at_top) begin
        nxt_count = T8PWM_BOTTOM;
      end else begin
        nxt_count = count_ff + T8PWM_ONE;
      end
      if ((wgm == T8PWM_WGM_FAST_CMP) ? at_top : (count_ff == T8PWM_MAX)) begin
        flag_set[T8PWM_FLAG_OVF] = 1'b1;
      end
    end
    if (match) begin
      flag_set[T8PWM_FLAG_CMPA] = 1'b1;
    end
    // Compare value: immediate in non-PWM, latched at TOP in the PWM modes.
    if (is_nonpwm) begin
      nxt_cmp_act = cmp_buf_ff;
    end else if (tick && at_top && (dir_ff == T8PWM_UP)) begin
      nxt_cmp_act = cmp_buf_ff;
      if (is_pc && (cmp_act_ff == T8PWM_MAX) && (cmp_buf_ff != T8PWM_MAX)) begin
        nxt_leave_max = 1'b1;
      end
    end
    // Waveform generation per mode family.
    if (is_pc && tick) begin
      if ((count_ff == T8PWM_BOTTOM) && (dir_ff == T8PWM_DOWN)) begin
        // BOTTOM counts as the start of the up slope.
        nxt_leave_max = 1'b0;
        nxt_up_hit = match;
        if (com[1] && (match || leave_max_ff)) begin
          nxt_wave = up_res;
        end else if ((com == T8PWM_COM_TOGGLE) && wgm[2] && match) begin
          nxt_wave = ~wave_ff;
        end
      end else if (at_top && (dir_ff == T8PWM_UP)) begin
        if (com[1] && (cmp_act_ff == top)) begin
          nxt_wave = down_res;
        end else if (com[1] && !up_hit_ff) begin
          nxt_wave = up_res;
        end else if ((com == T8PWM_COM_TOGGLE) && wgm[2] && match) begin
          nxt_wave = ~wave_ff;
        end
      end else if (match) begin
        if (dir_ff == T8PWM_UP) begin
          nxt_up_hit = 1'b1;
        end
        if (com[1]) begin
          nxt_wave = (dir_ff == T8PWM_UP) ? up_res : down_res;
        end else if ((com == T8PWM_COM_TOGGLE) && wgm[2]) begin
          nxt_wave = ~wave_ff;
        end
      end
    end else if (is_fast && tick) begin
      if (com[1] && at_top) begin
        nxt_wave = down_res;
      end else if (com[1] && match) begin
        nxt_wave = up_res;
      end else if ((com == T8PWM_COM_TOGGLE) && wgm[2] && match) begin
        nxt_wave = ~wave_ff;
      end
    end else if (is_nonpwm && (match || force_a)) begin
      case (com)
        T8PWM_COM_TOGGLE: nxt_wave = ~wave_ff;
        T8PWM_COM_CLEAR: nxt_wave = 1'b0;
        T8PWM_COM_SET: nxt_wave = 1'b1;
        default: nxt_wave = wave_ff;
      endcase
    end
    // Register writes; a counter write wins over the tick.
    if (i_io_req.wr) begin
      case (i_io_req.addr)
        T8PWM_ADDR_CTRL_A: begin
          nxt_ctrl_a = i_io_req.wdata;
          nxt_ctrl_a.rsvd = 2'h0;
        end
        T8PWM_ADDR_CTRL_B: nxt_ctrl_b = {4'h0, i_io_req.wdata[3:0]};
        T8PWM_ADDR_COUNT: nxt_count = i_io_req.wdata;
        T8PWM_ADDR_CMP_A: nxt_cmp_buf = i_io_req.wdata;
        T8PWM_ADDR_FLAGS: flag_clr = i_io_req.wdata[1:0];
        default: nxt_cmp_buf = cmp_buf_ff;
      endcase
    end
    // A flag set in the same cycle as its clear is kept.
    nxt_flags = (flags_ff & ~flag_clr) | flag_set;
    if (i_io_req.rd) begin
      case (i_io_req.addr)
        T8PWM_ADDR_CTRL_A: nxt_rdata = ctrl_a_ff;
        T8PWM_ADDR_CTRL_B: nxt_rdata = ctrl_b_ff;
        T8PWM_ADDR_COUNT: nxt_rdata = count_ff;
        T8PWM_ADDR_CMP_A: nxt_rdata = cmp_buf_ff;
        T8PWM_ADDR_FLAGS: nxt_rdata = {6'h00, flags_ff};
        default: nxt_rdata = T8PWM_RST_BYTE;
      endcase
    end
    // The waveform takes the pin only while wave_conn marks the output mode as connected.
    nxt_pin_out = wave_conn ? wave_ff : i_port_data_a;
    nxt_pin_oe_n = ~i_port_dir_a;
  end

  // Registers all state; everything resets to zero except the pin driver enable, which resets high.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_a_ff <= T8PWM_RST_BYTE;
      ctrl_b_ff <= T8PWM_RST_BYTE;
      count_ff <= T8PWM_RST_BYTE;
      cmp_buf_ff <= T8PWM_RST_BYTE;
      cmp_act_ff <= T8PWM_RST_BYTE;
      dir_ff <= T8PWM_UP;
      flags_ff <= 2'h0;
      wave_ff <= 1'b0;
      leave_max_ff <= 1'b0;
      up_hit_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
      rdata_ff <= T8PWM_RST_BYTE;
    end else begin
      ctrl_a_ff <= nxt_ctrl_a;
      ctrl_b_ff <= nxt_ctrl_b;
      count_ff <= nxt_count;
      cmp_buf_ff <= nxt_cmp_buf;
      cmp_act_ff <= nxt_cmp_act;
      dir_ff <= nxt_dir;
      flags_ff <= nxt_flags;
      wave_ff <= nxt_wave;
      leave_max_ff <= nxt_leave_max;
      up_hit_ff <= nxt_up_hit;
      pin_out_ff <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_io_rdata = rdata_ff;
  assign o_wave_out_a = wave_ff;
  assign o_pin_a_out = pin_out_ff;
  assign o_pin_a_oe_n = pin_oe_n_ff;
  assign o_overflow_flag = flags_ff[T8PWM_FLAG_OVF];
  assign o_compare_a_flag = flags_ff[T8PWM_FLAG_CMPA];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Tick at the top of an up slope in phase-correct mode.
  sequence s_reach_top;
    tick && is_pc && (dir_ff == T8PWM_UP) && at_top && (top != T8PWM_BOTTOM) && !i_io_req.wr;
  endsequence
  // Tick at the bottom of a down slope in phase-correct mode.
  sequence s_reach_bottom;
    tick && is_pc && (dir_ff == T8PWM_DOWN) && (count_ff == T8PWM_BOTTOM) && !i_io_req.wr;
  endsequence

  a_pc_turn_top: assert property (s_reach_top |=>
    (dir_ff == T8PWM_DOWN) && (count_ff == $past(count_ff) - T8PWM_ONE))
    else $error("Counter did not turn down after TOP.");
  a_pc_select_mode: assert property (s_reach_bottom |=>
    (dir_ff == T8PWM_UP) && (count_ff == T8PWM_ONE) && (wgm[1:0] == 2'h1))
    else $error("Phase-correct counter did not turn up at BOTTOM.");
  a_pc_fixed_top: assert property (tick && (wgm == T8PWM_WGM_PC_FIXED)
    && (dir_ff == T8PWM_UP) && (count_ff < T8PWM_MAX) && !i_io_req.wr |=> dir_ff == T8PWM_UP)
    else $error("Fixed TOP turned before MAX.");
  a_ovf_bottom: assert property (s_reach_bottom |=> o_overflow_flag)
    else $error("Overflow flag missing at BOTTOM.");
  a_pc_noninv_up: assert property (match && is_pc && (com == T8PWM_COM_CLEAR)
    && (dir_ff == T8PWM_UP) && !at_top && (count_ff != T8PWM_BOTTOM) |=> !wave_ff)
    else $error("Non-inverted up match did not clear.");
  a_pc_inv_down: assert property (match && is_pc && (com == T8PWM_COM_SET)
    && (dir_ff == T8PWM_DOWN) && (count_ff != T8PWM_BOTTOM) |=> !wave_ff)
    else $error("Inverted down match did not clear.");
  a_pwm_toggle: assert property (match && is_pc && (com == T8PWM_COM_TOGGLE)
    && (count_ff != T8PWM_BOTTOM) && !at_top |=> wave_ff == ($past(wave_ff) ^ $past(wgm[2])))
    else $error("Toggle mode acted against the high mode bit.");
  a_pin_override: assert property (wave_conn
    |=> o_pin_a_out == $past(wave_ff))
    else $error("Pin does not follow the waveform.");
  a_nonpwm_set: assert property (match && is_nonpwm && (com == T8PWM_COM_SET) |=> wave_ff)
    else $error("Non-PWM set on match failed.");
  a_fast_bottom: assert property (tick && is_fast && at_top && (com == T8PWM_COM_CLEAR)
    |=> wave_ff)
    else $error("Fast PWM did not set at BOTTOM.");
  a_pc_top_act: assert property (s_reach_top ##0 (com == T8PWM_COM_CLEAR)
    && (cmp_act_ff == top) |=> wave_ff)
    else $error("Compare at TOP not applied at TOP.");
  a_tick_stopped: assert property ((ctrl_b_ff[2:0] == T8PWM_CS_STOP) [*2] |-> !tick)
    else $error("Tick seen with the tick source stopped.");
  a_cmp_dbl_buf: assert property (is_pc && !i_io_req.wr && !(tick && at_top)
    |=> cmp_act_ff == $past(cmp_act_ff))
    else $error("Active compare changed away from TOP.");
endmodule // t8pwm_core

// *** dv/t8pwm_pin_load.sv ***
// Board-side load on the channel A pin: the block's driver plus a pull resistor.
`timescale 1ns/1ps
module t8pwm_pin_load #(
  parameter logic PULL_LEVEL = 1'b1  // Level of the pull resistor on the board.
) (
  input wire logic i_pin_out,
  input wire logic i_pin_oe_n,
  output logic o_pad
);
  // The pad carries the block's value only while its driver is on.
  // Otherwise the pull resistor wins, so a stale drive value never leaks through.
  assign o_pad = i_pin_oe_n ? PULL_LEVEL : i_pin_out;
endmodule // t8pwm_pin_load

// *** dv/test_timer8_phase_correct_pwm_out.sv ***
// Self-checking bench for the 8-bit timer waveform block.
`timescale 1ns/1ps
module test_timer8_phase_correct_pwm_out;
  import t8pwm_pkg::*;
  localparam int TOP_FIXED = 255;  // Fixed TOP of the 0xFF modes.
  localparam int PC_PERIOD = 2 * TOP_FIXED;  // Ticks in one dual-slope period.
  localparam int WAIT_MAX = 20000;  // Bound on any wait for an edge.
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  t8pwm_io_req_t i_io_req = '0;
  logic i_port_data_a = 1'b0;
  logic i_port_dir_a = 1'b0;
  logic [7:0] o_io_rdata;
  logic o_wave_out_a;
  logic o_pin_a_out;
  logic o_pin_a_oe_n;
  logic o_overflow_flag;
  logic o_compare_a_flag;
  logic pad;  // Resolved pin level seen by the board.
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;  // Free-running cycle count used for durations.
  logic [31:0] rnd = 32'haab7;  // Random state, fixed start.

  // Clock of 5 ns period.
  always #2.5 i_clk = ~i_clk;

  // Cycle counter for measuring widths and periods.
  always @(posedge i_clk) cyc <= cyc + 1;

  t8pwm_core uut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_io_req(i_io_req),
    .i_port_data_a(i_port_data_a),
    .i_port_dir_a(i_port_dir_a),
    .o_io_rdata(o_io_rdata),
    .o_wave_out_a(o_wave_out_a),
    .o_pin_a_out(o_pin_a_out),
    .o_pin_a_oe_n(o_pin_a_oe_n),
    .o_overflow_flag(o_overflow_flag),
    .o_compare_a_flag(o_compare_a_flag)
  );

  t8pwm_pin_load #(.PULL_LEVEL(1'b1)) load (
    .i_pin_out(o_pin_a_out),
    .i_pin_oe_n(o_pin_a_oe_n),
    .o_pad(pad)
  );

  // Linear feedback shift register step for repeatable random values.
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Control A byte from output mode and low waveform mode bits.
  function automatic logic [7:0] ctl(logic [1:0] com, logic [1:0] wgm);
    return {com, 4'h0, wgm};
  endfunction

  // Expected high time of a dual-slope output with fixed TOP.
  function automatic int pc_high(logic [7:0] c, int com);
    return (com == 2) ? 2 * int'(c) : PC_PERIOD - 2 * int'(c);
  endfunction

  // Expected high time of a single-slope output with fixed TOP.
  function automatic int fast_high(logic [7:0] c, int com);
    return (com == 2) ? int'(c) + 1 : TOP_FIXED - int'(c);
  endfunction

  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_int(string what, int exp, int got);
    total_checks++;
    if (got != exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // One write pulse; the request drops at the next edge.
  task automatic io_wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_io_req <= '0;
  endtask

  // One read pulse; data stands from the cycle after the read edge.
  task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
    @(posedge i_clk);
    i_io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    i_io_req <= '0;
    @(posedge i_clk);
    #1;
    check_byte(what, exp, o_io_rdata);
  endtask

  // Waits for the wave or the overflow flag to reach a level, bounded.
  task automatic wait_sig(bit ovf, logic lvl);
    int n;
    n = 0;
    while ((ovf ? o_overflow_flag : o_wave_out_a) !== lvl && n < WAIT_MAX) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= WAIT_MAX) check_int("wait bound", 0, n);
  endtask

  // Measures one full high pulse and the period that follows it.
  task automatic measure(string what, int eh, int ep);
    int t0;
    @(posedge i_clk);
    #1;
    wait_sig(1'b0, 1'b0);
    wait_sig(1'b0, 1'b1);
    t0 = cyc;
    wait_sig(1'b0, 1'b0);
    check_int(what, eh, cyc - t0);
    wait_sig(1'b0, 1'b1);
    check_int(what, ep, cyc - t0);
  endtask

  // Counts cycles in which the wave leaves the expected steady level.
  task automatic hold_level(string what, logic lvl);
    int bad;
    bad = 0;
    repeat (PC_PERIOD + 10) begin
      @(posedge i_clk);
      #1;
      if (o_wave_out_a !== lvl) bad++;
    end
    check_int(what, 0, bad);
  endtask

  // Time between two overflow flag rises, cleared in between.
  task automatic flag_gap(int ep);
    int t0;
    io_wr(T8PWM_ADDR_FLAGS, 8'h03);
    @(posedge i_clk);
    #1;
    wait_sig(1'b1, 1'b1);
    t0 = cyc;
    io_wr(T8PWM_ADDR_FLAGS, 8'h01);
    @(posedge i_clk);
    #1;
    wait_sig(1'b1, 1'b1);
    check_int("overflow gap", ep, cyc - t0);
  endtask

  // The pin copies the port data when the waveform is disconnected.
  task automatic port_check(string what);
    repeat (4) begin
      rnd = lfsr_next(rnd);
      @(posedge i_clk);
      i_port_data_a <= rnd[0];
      @(posedge i_clk);
      @(posedge i_clk);
      #1;
      check_byte(what, {7'd0, i_port_data_a}, {7'd0, pad});
    end
  endtask

  // The pin follows the wave one cycle later when connected.
  task automatic pin_wave();
    logic w;
    @(posedge i_clk);
    #1;
    w = o_wave_out_a;
    @(posedge i_clk);
    #1;
    check_byte("pin wave", {7'd0, w}, {7'd0, pad});
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the expected run of about 30000 cycles.
  initial begin
    repeat (90000) @(posedge i_clk);
    errors++;
    summarize();
  end

  // Main sequence: registers, port path, then each waveform family.
  initial begin
    logic [7:0] c;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk("ctrl a reset", T8PWM_ADDR_CTRL_A, 8'h00);
    rd_chk("flags reset", T8PWM_ADDR_FLAGS, 8'h00);
    check_byte("pad released", 8'h01, {7'd0, pad});
    rd_chk("unmapped read", 8'h50, 8'h00);
    io_wr(T8PWM_ADDR_CTRL_A, 8'hFF);
    rd_chk("ctrl a bits", T8PWM_ADDR_CTRL_A, 8'hF3);
    io_wr(T8PWM_ADDR_CTRL_A, 8'h00);
    i_port_dir_a <= 1'b1;
    port_check("port path");
    io_wr(T8PWM_ADDR_CTRL_B, 8'h01);
    // Duty sweep over corner and random compare values, both polarities.
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      c = (i < 2) ? 8'h01 : (i < 4) ? 8'hFE : ({1'b0, rnd[6:0]} + 8'h02);
      io_wr(T8PWM_ADDR_CMP_A, c);
      io_wr(T8PWM_ADDR_CTRL_A, ctl(2'(2 + i % 2), 2'h1));
      repeat (600) @(posedge i_clk);
      measure("pc duty", pc_high(c, 2 + i % 2), PC_PERIOD);
    end
    pin_wave();
    // Extreme compare values give a steady level.
    for (int i = 0; i < 4; i++) begin
      c = i[0] ? 8'hFF : 8'h00;
      io_wr(T8PWM_ADDR_CMP_A, c);
      io_wr(T8PWM_ADDR_CTRL_A, ctl(2'(2 + i / 2), 2'h1));
      repeat (1100) @(posedge i_clk);
      hold_level("pc extreme", i[0] ^ i[1]);
    end
    flag_gap(PC_PERIOD);
    io_wr(T8PWM_ADDR_CTRL_B, {5'h00, T8PWM_CS_DIV8});
    flag_gap(8 * PC_PERIOD);
    // Compare-defined TOP with toggle output: stop, rewind, then restart.
    rnd = lfsr_next(rnd);
    c = {2'b00, rnd[5:0]} + 8'h10;
    io_wr(T8PWM_ADDR_CTRL_B, 8'h00);
    io_wr(T8PWM_ADDR_COUNT, 8'h00);
    io_wr(T8PWM_ADDR_CMP_A, c);
    io_wr(T8PWM_ADDR_CTRL_A, ctl(2'h1, 2'h1));
    io_wr(T8PWM_ADDR_CTRL_B, 8'h09);
    repeat (1200) @(posedge i_clk);
    measure("pc top toggle", 2 * int'(c), 4 * int'(c));
    io_wr(T8PWM_ADDR_CTRL_B, 8'h01);
    port_check("toggle off");
    // Non-PWM: toggle, set and clear on match.
    io_wr(T8PWM_ADDR_CMP_A, 8'h40);
    io_wr(T8PWM_ADDR_CTRL_A, ctl(2'h1, 2'h0));
    repeat (600) @(posedge i_clk);
    measure("normal toggle", TOP_FIXED + 1, 2 * (TOP_FIXED + 1));
    io_wr(T8PWM_ADDR_FLAGS, 8'h03);
    io_wr(T8PWM_ADDR_CTRL_A, ctl(2'h3, 2'h0));
    repeat (300) @(posedge i_clk);
    #1;
    check_byte("normal set", 8'h01, {7'd0, o_wave_out_a});
    check_byte("compare a flag", 8'h01, {7'd0, o_compare_a_flag});
    io_wr(T8PWM_ADDR_CTRL_A, ctl(2'h2, 2'h0));
    repeat (300) @(posedge i_clk);
    #1;
    check_byte("normal clear", 8'h00, {7'd0, o_wave_out_a});
    // Single-slope duty in both polarities.
    c = {1'b0, rnd[13:7]} + 8'h02;
    io_wr(T8PWM_ADDR_CMP_A, c);
    for (int k = 2; k < 4; k++) begin
      io_wr(T8PWM_ADDR_CTRL_A, ctl(2'(k), 2'h3));
      repeat (600) @(posedge i_clk);
      measure("fast duty", fast_high(c, k), TOP_FIXED + 1);
    end
    // No tick source: the counter stands still.
    io_wr(T8PWM_ADDR_CTRL_B, 8'h00);
    io_wr(T8PWM_ADDR_COUNT, 8'h37);
    io_wr(T8PWM_ADDR_FLAGS, 8'h03);
    rd_chk("count stopped", T8PWM_ADDR_COUNT, 8'h37);
    repeat (50) @(posedge i_clk);
    rd_chk("count still", T8PWM_ADDR_COUNT, 8'h37);
    rd_chk("flags stopped", T8PWM_ADDR_FLAGS, 8'h00);
    summarize();
  end
endmodule // test_timer8_phase_correct_pwm_out
